// ---- design/bst_consts.svh ----
/*
   constants of the boundary-scan test port: lengths, opcodes,
   capture pattern, default sizes.
   assumes inclusion by bare name from package and design files.
*/
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

`define BST_IR_LEN        6
`define BST_IR_CAPTURE    6'h11
`define BST_OP_EXTEST     6'h26
`define BST_OP_SAMPLE     6'h01
`define BST_OP_IDCODE     6'h09
`define BST_OP_CFG_IN     6'h05
`define BST_OP_CFG_OUT    6'h04
`define BST_OP_BYPASS     6'h3f
`define BST_ID_LEN        32
`define BST_ID_CODE       32'h0000_0001
`define BST_CFG_LEN       32
`define BST_CFG_AW        4
`define BST_IO_COUNT      4
`define BST_CELLS_PER_IO  3
`define BST_CELL_IN       0
`define BST_CELL_OUT      1
`define BST_CELL_OE       2
`define BST_TMS_RESET_CLKS 3'h5

`endif

// ---- design/bst_pkg.sv ----
/*
   types of the boundary-scan test port: controller states,
   data register selection, configuration word carrier.
   assumes bst_consts.svh on the include path.
*/
`include "bst_consts.svh"

package bst_pkg;

   typedef enum logic [15:0] {
      st_reset  = 16'h0001,
      st_idle   = 16'h0002,
      st_sel_dr = 16'h0004,
      st_cap_dr = 16'h0008,
      st_sh_dr  = 16'h0010,
      st_ex1_dr = 16'h0020,
      st_pa_dr  = 16'h0040,
      st_ex2_dr = 16'h0080,
      st_upd_dr = 16'h0100,
      st_sel_ir = 16'h0200,
      st_cap_ir = 16'h0400,
      st_sh_ir  = 16'h0800,
      st_ex1_ir = 16'h1000,
      st_pa_ir  = 16'h2000,
      st_ex2_ir = 16'h4000,
      st_upd_ir = 16'h8000
   } bst_tap_state_t;

   typedef enum logic [2:0] {
      dr_bypass   = 3'h0,
      dr_idcode   = 3'h1,
      dr_boundary = 3'h2,
      dr_cfg_in   = 3'h3,
      dr_cfg_out  = 3'h4
   } bst_dr_sel_t;

   typedef struct packed {
      logic [`BST_CFG_AW-1:0]  addr;
      logic [`BST_CFG_LEN-1:0] data;
   } bst_cfg_t;

   // active instruction to data register
   function automatic bst_dr_sel_t bst_dr_decode(input logic [`BST_IR_LEN-1:0] ir);
      case (ir)
         `BST_OP_IDCODE:  bst_dr_decode = dr_idcode;
         `BST_OP_EXTEST:  bst_dr_decode = dr_boundary;
         `BST_OP_SAMPLE:  bst_dr_decode = dr_boundary;
         `BST_OP_CFG_IN:  bst_dr_decode = dr_cfg_in;
         `BST_OP_CFG_OUT: bst_dr_decode = dr_cfg_out;
         default:         bst_dr_decode = dr_bypass;
      endcase
   endfunction

endpackage

// ---- design/bst_cfg_mem.sv ----
/*
   configuration word store: one write port, one read port,
   read data registered.
   assumes one clock, writes and reads by the caller on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module bst_cfg_mem
   import bst_pkg::*;
#(
   parameter int WIDTH = `BST_CFG_LEN,
   parameter int AW    = `BST_CFG_AW
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // read port
   input  wire logic [AW-1:0]    rd_addr,
   output var  logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= store[rd_addr];
      end
   end

endmodule

`default_nettype wire

// ---- design/bst_tap_fsm.sv ----
/*
   sixteen-state test port controller, stepped by mode select.
   assumes a reset already released in step with tck.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module bst_tap_fsm
   import bst_pkg::*;
(
   // test clock and reset
   input  wire logic     tck,
   input  wire logic     tck_rst_n,
   // mode select
   input  wire logic     tms,
   // controller state
   output var  bst_tap_state_t state
);

   bst_tap_state_t next_state;
   logic [2:0]     tms_run;

   always_comb begin
      case (state)
         st_reset:  next_state = tms ? st_reset  : st_idle;
         st_idle:   next_state = tms ? st_sel_dr : st_idle;
         st_sel_dr: next_state = tms ? st_sel_ir : st_cap_dr;
         st_cap_dr: next_state = tms ? st_ex1_dr : st_sh_dr;
         st_sh_dr:  next_state = tms ? st_ex1_dr : st_sh_dr;
         st_ex1_dr: next_state = tms ? st_upd_dr : st_pa_dr;
         st_pa_dr:  next_state = tms ? st_ex2_dr : st_pa_dr;
         st_ex2_dr: next_state = tms ? st_upd_dr : st_sh_dr;
         st_upd_dr: next_state = tms ? st_sel_dr : st_idle;
         st_sel_ir: next_state = tms ? st_reset  : st_cap_ir;
         st_cap_ir: next_state = tms ? st_ex1_ir : st_sh_ir;
         st_sh_ir:  next_state = tms ? st_ex1_ir : st_sh_ir;
         st_ex1_ir: next_state = tms ? st_upd_ir : st_pa_ir;
         st_pa_ir:  next_state = tms ? st_ex2_ir : st_pa_ir;
         st_ex2_ir: next_state = tms ? st_upd_ir : st_sh_ir;
         st_upd_ir: next_state = tms ? st_sel_dr : st_idle;
         default:   next_state = st_reset;
      endcase
   end

   // state moves on rising tck only
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         state <= st_reset;
      end else begin
         state <= next_state;
      end
   end

   // run of mode-select highs, for checking
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tms_run <= 3'h0;
      end else if (!tms) begin
         tms_run <= 3'h0;
      end else if (tms_run != `BST_TMS_RESET_CLKS) begin
         tms_run <= tms_run + 3'h1;
      end
   end

   tms_reset_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (tms_run == `BST_TMS_RESET_CLKS) |-> (state == st_reset))
      else $error("five mode-select highs did not reach reset");

   sel_dr_step_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (state == st_sel_dr && !tms) |=> (state == st_cap_dr))
      else $error("select-dr with low mode select did not capture");

endmodule

`default_nettype wire

// ---- design/bst_tap_top.sv ----
/*
   boundary-scan test port: controller, instruction register, bypass,
   identification, boundary and configuration data registers, and the
   crossing of configuration words into the system clock domain.
   assumes tck, tms, tdi come from an outside controller; tck may stop
   between scans; the configuration reset of the device is held high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module bst_tap_top
   import bst_pkg::*;
#(
   parameter int                     IO_COUNT = `BST_IO_COUNT,
   parameter logic [`BST_ID_LEN-1:0] ID_CODE  = `BST_ID_CODE  // value arbitrary
) (
   // system side
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // test port
   input  wire logic                tck,
   input  wire logic                tms,
   input  wire logic                tdi,
   output var  logic                tdo,
   output var  logic                tdo_oe_n,
   // boundary cells
   input  wire logic [IO_COUNT-1:0] pad_in,
   output var  logic [IO_COUNT-1:0] pad_out,
   output var  logic [IO_COUNT-1:0] pad_oe_n,
   output var  logic                extest_active,
   // configuration words
   output var  bst_cfg_t            cfg_word,
   output var  logic                cfg_word_valid
);

   localparam int BSR_LEN = IO_COUNT * `BST_CELLS_PER_IO;
   localparam int IRL     = `BST_IR_LEN;
   localparam int CFL     = `BST_CFG_LEN;
   localparam int AW      = `BST_CFG_AW;

   // test clock domain
   logic                 tck_rst_q;
   logic                 tck_rst_n;
   bst_tap_state_t       state;
   bst_dr_sel_t          dr_sel;
   logic [IRL-1:0]       ir_shift;
   logic [IRL-1:0]       ir_hold;
   logic [IRL-1:0]       next_ir_hold;
   logic                 bypass_bit;
   logic [`BST_ID_LEN-1:0] id_sr;
   logic [BSR_LEN-1:0]   bsr_sr;
   logic [CFL-1:0]       cfg_sr;
   logic [IO_COUNT-1:0]  pad_meta;
   logic [IO_COUNT-1:0]  pad_sync;
   logic                 shifting;
   logic                 serial_out;
   logic                 tdo_rise;
   logic [CFL-1:0]       cfg_hold;
   logic                 cfg_tgl;
   logic                 rb_req;
   logic                 rb_ack_meta;
   logic                 rb_ack_sync;
   // system clock domain
   logic                 cfg_tgl_meta;
   logic                 cfg_tgl_sync;
   logic                 cfg_tgl_seen;
   logic                 rb_req_meta;
   logic                 rb_req_sync;
   logic                 rb_ack;
   logic                 rb_fetch;
   logic [CFL-1:0]       rb_word;
   logic [AW-1:0]        wr_ptr;
   logic [AW-1:0]        rd_ptr;
   logic [CFL-1:0]       mem_rdata;
   logic                 cfg_new;

   // power-on reset released in step with tck
   always_ff @(posedge tck or negedge reset_n) begin
      if (!reset_n) begin
         tck_rst_q <= 1'b0;
         tck_rst_n <= 1'b0;
      end else begin
         tck_rst_q <= 1'b1;
         tck_rst_n <= tck_rst_q;
      end
   end

   // controller, steered by tms only, no test reset pin
   bst_tap_fsm u_fsm (
      .tck       (tck),
      .tck_rst_n (tck_rst_n),
      .tms       (tms),
      .state     (state)
   );

   assign dr_sel   = bst_dr_decode(ir_hold);
   assign shifting = (state == st_sh_ir) || (state == st_sh_dr);

   // instruction shift register
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_shift <= `BST_IR_CAPTURE;
      end else if (state == st_cap_ir) begin
         ir_shift <= `BST_IR_CAPTURE;
      end else if (state == st_sh_ir) begin
         ir_shift <= {tdi, ir_shift[IRL-1:1]};
      end
   end

   always_comb begin
      next_ir_hold = ir_hold;
      if (state == st_reset) begin
         next_ir_hold = `BST_OP_IDCODE;
      end else if (state == st_upd_ir) begin
         next_ir_hold = ir_shift;
      end
   end

   // instruction latch, falling edge
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_hold       <= `BST_OP_IDCODE;
         extest_active <= 1'b0;
      end else begin
         ir_hold       <= next_ir_hold;
         extest_active <= (next_ir_hold == `BST_OP_EXTEST);
      end
   end

   // bypass stage
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bypass_bit <= 1'b0;
      end else if (state == st_cap_dr && dr_sel == dr_bypass) begin
         bypass_bit <= 1'b0;
      end else if (state == st_sh_dr && dr_sel == dr_bypass) begin
         bypass_bit <= tdi;
      end
   end

   // identification register
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         id_sr <= '0;
      end else if (state == st_cap_dr && dr_sel == dr_idcode) begin
         id_sr <= ID_CODE;
      end else if (state == st_sh_dr && dr_sel == dr_idcode) begin
         id_sr <= {tdi, id_sr[`BST_ID_LEN-1:1]};
      end
   end

   // pad levels into the tck domain
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         pad_meta <= '0;
         pad_sync <= '0;
      end else begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
      end
   end

   // boundary register: per pad input, output, enable cells
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_sr <= '0;
      end else if (state == st_cap_dr && dr_sel == dr_boundary) begin
         for (int i = 0; i < IO_COUNT; i++) begin
            bsr_sr[i*`BST_CELLS_PER_IO + `BST_CELL_IN]  <= pad_sync[i];
            bsr_sr[i*`BST_CELLS_PER_IO + `BST_CELL_OUT] <= pad_out[i];
            bsr_sr[i*`BST_CELLS_PER_IO + `BST_CELL_OE]  <= pad_oe_n[i];
         end
      end else if (state == st_sh_dr && dr_sel == dr_boundary) begin
         bsr_sr <= {tdi, bsr_sr[BSR_LEN-1:1]};
      end
   end

   // boundary update latches, falling edge in update-dr
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         pad_out  <= '0;
         pad_oe_n <= '1;
      end else if (state == st_upd_dr && dr_sel == dr_boundary) begin
         for (int i = 0; i < IO_COUNT; i++) begin
            pad_out[i]  <= bsr_sr[i*`BST_CELLS_PER_IO + `BST_CELL_OUT];
            pad_oe_n[i] <= bsr_sr[i*`BST_CELLS_PER_IO + `BST_CELL_OE];
         end
      end
   end

   // readback acknowledge into tck domain
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         rb_ack_meta <= 1'b0;
         rb_ack_sync <= 1'b0;
      end else begin
         rb_ack_meta <= rb_ack;
         rb_ack_sync <= rb_ack_meta;
      end
   end

   // configuration register: load in, read back out
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         cfg_sr <= '0;
         rb_req <= 1'b0;
      end else if (state == st_cap_dr && dr_sel == dr_cfg_out) begin
         if (rb_ack_sync != rb_req) begin
            cfg_sr <= rb_word;
            rb_req <= ~rb_req;
         end else begin
            cfg_sr <= '0;
         end
      end else if (state == st_sh_dr && (dr_sel == dr_cfg_in || dr_sel == dr_cfg_out)) begin
         cfg_sr <= {tdi, cfg_sr[CFL-1:1]};
      end
   end

   // finished word handed over by toggle, held until the next
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         cfg_hold <= '0;
         cfg_tgl  <= 1'b0;
      end else if (state == st_upd_dr && dr_sel == dr_cfg_in) begin
         cfg_hold <= cfg_sr;
         cfg_tgl  <= ~cfg_tgl;
      end
   end

   always_comb begin
      case (1'b1)
         (state == st_sh_ir):      serial_out = ir_shift[0];
         (dr_sel == dr_idcode):    serial_out = id_sr[0];
         (dr_sel == dr_boundary):  serial_out = bsr_sr[0];
         (dr_sel == dr_cfg_in),
         (dr_sel == dr_cfg_out):   serial_out = cfg_sr[0];
         default:                  serial_out = bypass_bit;
      endcase
   end

   // data out on falling edge, released outside shifts
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo      <= 1'b1;
         tdo_oe_n <= 1'b1;
      end else begin
         tdo      <= shifting ? serial_out : 1'b1;
         tdo_oe_n <= !shifting;
      end
   end

   // data out level at each rising edge, for checking
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_rise <= 1'b1;
      end else begin
         tdo_rise <= tdo;
      end
   end

   // system side: word toggle and readback request
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_tgl_meta <= 1'b0;
         cfg_tgl_sync <= 1'b0;
         cfg_tgl_seen <= 1'b0;
         rb_req_meta  <= 1'b0;
         rb_req_sync  <= 1'b0;
      end else begin
         cfg_tgl_meta <= cfg_tgl;
         cfg_tgl_sync <= cfg_tgl_meta;
         cfg_tgl_seen <= cfg_tgl_sync;
         rb_req_meta  <= rb_req;
         rb_req_sync  <= rb_req_meta;
      end
   end

   assign cfg_new = cfg_tgl_sync != cfg_tgl_seen;

   // store each loaded word and present it to the user
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr         <= '0;
         cfg_word       <= '0;
         cfg_word_valid <= 1'b0;
      end else begin
         cfg_word_valid <= cfg_new;
         if (cfg_new) begin
            cfg_word.addr <= wr_ptr;
            cfg_word.data <= cfg_hold;
            wr_ptr        <= wr_ptr + 1'b1;
         end
      end
   end

   // prefetch the next stored word, never one not yet written
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr   <= '0;
         rb_fetch <= 1'b0;
         rb_ack   <= 1'b0;
         rb_word  <= '0;
      end else if (rb_fetch) begin
         rb_fetch <= 1'b0;
         rb_word  <= mem_rdata;
         rb_ack   <= ~rb_ack;
         rd_ptr   <= rd_ptr + 1'b1;
      end else if (rb_ack == rb_req_sync && rd_ptr != wr_ptr) begin
         rb_fetch <= 1'b1;
      end
   end

   bst_cfg_mem #(
      .WIDTH (CFL),
      .AW    (AW)
   ) u_mem (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .wr_en   (cfg_new),
      .wr_addr (wr_ptr),
      .wr_data (cfg_hold),
      .rd_addr (rd_ptr),
      .rd_data (mem_rdata)
   );

   ir_capture_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (state == st_cap_ir) |=> (ir_shift == `BST_IR_CAPTURE) && (ir_shift[1:0] == 2'h1))
      else $error("instruction capture pattern wrong");

   ir_shift_in_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (state == st_sh_ir) |=> (ir_shift[IRL-1] == $past(tdi)))
      else $error("instruction shift lost data in");

   ir_update_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      (state == st_upd_ir) |=> (ir_hold == $past(ir_shift)))
      else $error("instruction not latched in update");

   ir_default_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      (state == st_reset) |=> (ir_hold == `BST_OP_IDCODE) && !extest_active)
      else $error("reset did not select identification");

   bypass_delay_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (state == st_sh_dr && dr_sel == dr_bypass) |=> (bypass_bit == $past(tdi)))
      else $error("bypass stage did not delay one cycle");

   id_capture_a: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (state == st_cap_dr && dr_sel == dr_idcode) |=> (id_sr == ID_CODE))
      else $error("identification not captured");

   id_out_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      (state == st_sh_dr && dr_sel == dr_idcode) |=> (tdo == $past(id_sr[0])) && !tdo_oe_n)
      else $error("identification bit not on data out");

   tdo_release_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      !shifting |=> tdo_oe_n && tdo)
      else $error("data out driven outside a shift");

   tdo_edge_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      tdo == tdo_rise)
      else $error("data out moved outside falling edge");

   bsr_update_a: assert property (@(negedge tck) disable iff (!tck_rst_n)
      (state == st_upd_dr && dr_sel == dr_boundary) |=> (pad_oe_n[0] == $past(bsr_sr[`BST_CELL_OE])))
      else $error("boundary enable not updated");

   cfg_word_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cfg_new |=> cfg_word_valid && (cfg_word.data == $past(cfg_hold)))
      else $error("configuration word not delivered");

endmodule

`default_nettype wire

// ---- test/bst_ctl_model.sv ----
/*
   model of the outside test controller: drives tck, tms and tdi,
   samples the tdo line, runs tck only within its step task.
   assumes the tdo line is pulled up while the device releases it.
*/
`timescale 1ns/1ps
`default_nettype none

module bst_ctl_model (
   // test port
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe_n
);
   // pull-up when released
   wire logic tdo_line = tdo_oe_n ? 1'b1 : tdo;

   // configuration reset of the device taken as held high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // one test clock, mode and data set while tck low
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #7.5;
      q   = tdo_line;
      tck = 1'b1;
      #7.5;
      tck = 1'b0;
   endtask

   task automatic go(input logic m);
      logic q;
      step(m, 1'b1, q);
   endtask

   task automatic reset5;
      repeat (5) go(1'b1);
   endtask

   // idle to idle scan, lsb first
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      go(1'b1);
      if (ir) go(1'b1);
      go(1'b0);
      go(1'b0);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], q);
         dout[k] = q;
      end
      go(1'b1);
      go(1'b0);
   endtask
endmodule

`default_nettype wire

// ---- test/test_boundary_scan_tap_port.sv ----
/*
   self-checking bench of the boundary-scan test port.
   assumes bst_ctl_model as the outside controller on tck, tms, tdi.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module test_boundary_scan_tap_port import bst_pkg::*;;
   localparam logic [31:0] ID = 32'h5a3c_0f01;  // value arbitrary
   logic        sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe_n;
   logic        extest_active, cfg_word_valid;
   logic [3:0]  pad_in, pad_out, pad_oe_n;
   bst_cfg_t    cfg_word, got_word;
   logic [31:0] rd;
   int          fails = 0;
   int          compares = 0;
   int          words = 0;

   bst_tap_top #(.ID_CODE(ID)) dut_u (
      .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .extest_active(extest_active),
      .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid));

   bst_ctl_model ctl_u (
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // catch configuration word pulses
   always @(posedge sys_clk) begin
      if (cfg_word_valid === 1'b1) begin
         got_word <= cfg_word;
         words    <= words + 1;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic t_idcode;
      ctl_u.scan(1'b0, 32, 32'h0, rd);
      check(rd, ID, "id after reset");
      check({tdo_oe_n, tdo}, 2'b11, "tdo released");
   endtask

   task automatic t_ir_capture;
      ctl_u.scan(1'b1, 6, 32'(`BST_OP_BYPASS), rd);
      check(rd[5:0], `BST_IR_CAPTURE, "ir capture");
   endtask

   task automatic t_bypass;
      logic [5:0] ops [2] = '{`BST_OP_BYPASS, 6'h2a};
      for (int k = 0; k < 2; k++) begin
         ctl_u.scan(1'b1, 6, 32'(ops[k]), rd);
         ctl_u.scan(1'b0, 8, 32'h0000_00a5, rd);
         check(rd[7:0], 8'h4a, "bypass delay");
      end
   endtask

   task automatic t_tlr;
      ctl_u.go(1'b1);
      repeat (4) ctl_u.go(1'b0);
      ctl_u.reset5();
      ctl_u.go(1'b0);
      ctl_u.scan(1'b0, 32, 32'h0, rd);
      check(rd, ID, "id after mode reset");
   endtask

   task automatic t_boundary;
      logic [11:0] din = 12'hc63;
      logic [11:0] exp;
      logic [3:0]  eo;
      logic [3:0]  ee;
      @(negedge sys_clk) pad_in = 4'ha;
      for (int i = 0; i < 4; i++) begin
         exp[3*i +: 3] = {1'b1, 1'b0, pad_in[i]};
         eo[i] = din[3*i+1];
         ee[i] = din[3*i+2];
      end
      ctl_u.scan(1'b1, 6, 32'(`BST_OP_SAMPLE), rd);
      ctl_u.scan(1'b0, 12, 32'(din), rd);
      check(rd[11:0], exp, "boundary capture");
      check({pad_oe_n, pad_out}, {ee, eo}, "boundary update");
      check(extest_active, 1'b0, "not extest");
      ctl_u.scan(1'b1, 6, 32'(`BST_OP_EXTEST), rd);
      check(extest_active, 1'b1, "extest active");
   endtask

   task automatic t_cfg;
      logic [31:0] w [2] = '{32'hc0de_1234, 32'h8001_7ffe};
      int          n0;
      ctl_u.scan(1'b1, 6, 32'(`BST_OP_CFG_IN), rd);
      for (int k = 0; k < 2; k++) begin
         n0 = words;
         ctl_u.scan(1'b0, 32, w[k], rd);
         for (int t = 0; t < 40 && words == n0; t++) @(negedge sys_clk);
         check(32'(words - n0), 32'h1, "cfg word pulse");
         check(got_word.data, w[k], "cfg word data");
         check(got_word.addr, 4'(k), "cfg word index");
      end
      ctl_u.scan(1'b1, 6, 32'(`BST_OP_CFG_OUT), rd);
      repeat (4) ctl_u.go(1'b0);
      repeat (20) @(negedge sys_clk);
      ctl_u.scan(1'b0, 32, 32'h0, rd);
      check(rd, w[0], "cfg readback");
   endtask

   initial begin
      reset_n = 1'b0;
      pad_in  = 4'h0;
      fork
         repeat (8) @(posedge sys_clk);
         ctl_u.reset5();
      join
      @(negedge sys_clk) reset_n = 1'b1;
      ctl_u.reset5();
      ctl_u.go(1'b0);
      t_idcode;
      t_ir_capture;
      t_bypass;
      t_tlr;
      t_boundary;
      t_cfg;
      print_verdict;
   end

   initial begin
      #100us;
      fails++;
      print_verdict;
   end
endmodule

`default_nettype wire
